/* src/serial_line.sv */
`timescale 1ns/10ps

module serial_line (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Core side.
    input wire logic ir_mode,
    input wire logic baud_tick,
    input wire logic tx_serial,
    input wire logic [3:0] tx_phase,
    output logic rx_serial,
    // Line side.
    input wire logic rx_pin,
    output logic tx_pin
);

    typedef struct packed {
        logic [1:0] rx_s;
        logic [3:0] stretch;
        logic stretching;
        logic tx_pin;
        logic rx_serial;
    } line_state_t;

    line_state_t st_r;
    line_state_t st_nxt;

    // Line encoding and decoding for wired and infrared modes.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rx_s = {st_r.rx_s[0], rx_pin};
        if (ir_mode) begin
            st_nxt.tx_pin = ~tx_serial && (tx_phase < uart_pins_pkg::IR_PULSE_TICKS);
        end else begin
            st_nxt.tx_pin = tx_serial;
        end
        if (ir_mode) begin
            if (st_r.rx_s[1]) begin
                st_nxt.stretching = 1'b1;
                st_nxt.stretch = uart_pins_pkg::BIT_TICKS_M1;
            end else if (st_r.stretching && baud_tick) begin
                st_nxt.stretch = st_r.stretch - 4'h1;
                st_nxt.stretching = (st_r.stretch != 4'h0);
            end
            st_nxt.rx_serial = ~st_nxt.stretching;
        end else begin
            st_nxt.stretching = 1'b0;
            st_nxt.rx_serial = st_r.rx_s[1];
        end
    end

    // State register; the line idles at mark after reset.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_r <= '{rx_s: 2'h3, stretch: 4'h0, stretching: 1'b0,
                      tx_pin: 1'b1, rx_serial: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_pin = st_r.tx_pin;
    assign rx_serial = st_r.rx_serial;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_TX_WIRED: assert property (!ir_mode && tx_serial |=> tx_pin)
        else $error("Wired transmit pin not idle high.");
    AST_IR_PULSE: assert property (
        ir_mode && !st_r.rx_s[1] && !st_r.stretching |=> rx_serial)
        else $error("Infrared receive did not idle.");

endmodule : serial_line

/* src/uart_pin_ctrl.sv */
`timescale 1ns/10ps

// What this block does
// - Drive receiver-ready low while receive data waits.
// - Grounded mode strap selects PC mode with internal chip-select decode.
// - PC mode decodes host address bits 3 to 9.
// - Address-valid low validates address against strapped COM port.
// - Three strap inputs choose COM port and interrupt line.
// - Interrupt lines active high; unused lines float.
// - Route the UART interrupt onto the selected COM port's line.
// - Enable routed line only with modem control bit 3 and enabled sources.
// - PC mode drives first printer decode low on its address.
// - PC mode feeds internal 16x clock to receiver; pin freed.
// - PC mode drives second printer decode low on its address.
// - Transmit idles high wired; infrared sends active-high pulses.
// - Receive idles high wired, low in infrared mode.
// - Infrared receive pulses pass the infrared decoder first.
// - Far side holds receive at idle level, else break or errors.
// - Auto RTS flow control via feature bit 6, modem bit 1, enable bit 6.
// - RTS alternatively drives RS485 direction, extra feature bits 2 and 5.
// - Auto CTS stops transmit while CTS is deasserted.
// - Auto CTS enabled by feature bit 7, interrupt by enable bit 7.
// - DTR is an active-low ready or general purpose output.
module uart_pin_ctrl (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Core control registers and status.
    input wire uart_pins_pkg::core_ctl_t ctl,
    input wire uart_pins_pkg::core_sts_t sts,
    input wire logic ir_mode,
    input wire logic tx_serial,
    input wire logic [3:0] tx_phase,
    // Core side results.
    output logic rx_serial,
    output logic rx_clk_16x,
    output logic tx_hold,
    output logic flow_event,
    output logic com_select,
    output logic pc_mode,
    // Host pins.
    input wire uart_pins_pkg::host_pins_t host,
    input wire logic rclk_pin,
    input wire logic drive_disable_n,
    output logic rx_ready_n,
    output logic [2:0] irq_line_o,
    output logic [2:0] irq_line_oe,
    output logic baud_clock_out_n,
    output logic printer_port2_decode_n,
    // Serial and modem pins.
    input wire logic rx_pin,
    input wire logic cts_n,
    output logic tx_pin,
    output logic rts_n,
    output logic dtr_n
);

    typedef struct packed {
        logic [1:0] mode_s;
        logic [1:0][6:0] addr_s;
        logic [1:0] aen_s;
        logic [1:0][2:0] sel_s;
        logic [1:0] cts_s;
        logic [1:0] rclk_s;
        logic aen_d;
        logic cts_d;
        logic [2:0] port_sel;
        logic pc_mode;
        logic com_select;
        logic printer_port1_decode_n_n;
        logic printer_port2_decode_n_n;
        logic baud_out_n;
        logic rx_clk;
        logic [2:0] irq_o;
        logic [2:0] irq_oe;
        logic rx_ready_n;
        logic rts_n;
        logic dtr_n;
        logic tx_hold;
        logic flow_event;
    } pin_state_t;

    pin_state_t st_r;
    pin_state_t st_nxt;

    // Compares bits 9..3 of the host address with a port base.
    function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] base);
        addr_hit = (addr == base);
    endfunction : addr_hit

    // Base address of the COM port chosen by the straps.
    function automatic logic [6:0] com_base(input logic [2:0] sel);
        case (sel[1:0])
            2'h0: com_base = uart_pins_pkg::COM1_BASE;
            2'h1: com_base = uart_pins_pkg::COM2_BASE;
            2'h2: com_base = uart_pins_pkg::COM3_BASE;
            default: com_base = uart_pins_pkg::COM4_BASE;
        endcase
    endfunction : com_base

    // Request line chosen by the straps; the top strap forces line C.
    function automatic logic [2:0] irq_line_of(input logic [2:0] sel);
        if (sel[2]) begin
            irq_line_of = uart_pins_pkg::IRQ_C;
        end else if (sel[0]) begin
            irq_line_of = uart_pins_pkg::IRQ_B;
        end else begin
            irq_line_of = uart_pins_pkg::IRQ_A;
        end
    endfunction : irq_line_of

    logic [6:0] addr_now;
    logic irq_enable;
    logic rts_manual;
    logic auto_rts;
    logic rs485;

    // Synchronised pins and decoded enables seen by the next-state logic.
    always_comb begin
        addr_now = st_r.addr_s[1];
        irq_enable = ctl.modem_control_reg[uart_pins_pkg::MCR_IRQ_EN] &&
            (ctl.int_enable_reg[uart_pins_pkg::IER_SRC_MSB:uart_pins_pkg::IER_SRC_LSB] != 4'h0);
        rts_manual = ctl.modem_control_reg[uart_pins_pkg::MCR_RTS];
        auto_rts = ctl.enhanced_feature_reg[uart_pins_pkg::EFR_AUTO_RTS] && rts_manual;
        rs485 = ctl.extra_feature_reg[uart_pins_pkg::XFR_RS485_EN];
    end

    // Next state of all pin logic.
    always_comb begin
        st_nxt = st_r;
        st_nxt.mode_s = {st_r.mode_s[0], host.pc_mode_select_n};
        st_nxt.addr_s = {st_r.addr_s[0], host.host_addr};
        st_nxt.aen_s = {st_r.aen_s[0], host.isa_address_valid_n};
        st_nxt.sel_s = {st_r.sel_s[0], host.port_select};
        st_nxt.cts_s = {st_r.cts_s[0], cts_n};
        st_nxt.rclk_s = {st_r.rclk_s[0], rclk_pin};
        st_nxt.aen_d = st_r.aen_s[1];
        st_nxt.cts_d = st_r.cts_s[1];

        st_nxt.pc_mode = ~st_r.mode_s[1];

        if (st_r.aen_d && !st_r.aen_s[1]) begin
            st_nxt.port_sel = st_r.sel_s[1];
        end

        st_nxt.com_select = st_r.pc_mode && !st_r.aen_s[1] &&
            addr_hit(addr_now, com_base(st_r.port_sel));

        st_nxt.printer_port1_decode_n_n = ~(st_r.pc_mode && !st_r.aen_s[1] &&
            addr_hit(addr_now, uart_pins_pkg::PRINTER_PORT1_DECODE_N_BASE));
        st_nxt.printer_port2_decode_n_n = ~(st_r.pc_mode && !st_r.aen_s[1] &&
            addr_hit(addr_now, uart_pins_pkg::PRINTER_PORT2_DECODE_N_BASE));

        if (st_r.pc_mode) begin
            st_nxt.rx_clk = sts.baud_tick;
            st_nxt.baud_out_n = st_nxt.printer_port1_decode_n_n;
        end else begin
            st_nxt.rx_clk = st_r.rclk_s[1];
            st_nxt.baud_out_n = ~sts.baud_tick;
            st_nxt.printer_port2_decode_n_n = drive_disable_n;
        end

        if (st_r.pc_mode && irq_enable) begin
            st_nxt.irq_oe = irq_line_of(st_r.port_sel);
            st_nxt.irq_o = sts.uart_irq ? irq_line_of(st_r.port_sel) : 3'h0;
        end else begin
            st_nxt.irq_oe = 3'h0;
            st_nxt.irq_o = 3'h0;
        end

        st_nxt.rx_ready_n = ~sts.rx_data_ready;

        if (rs485) begin
            st_nxt.rts_n = ctl.extra_feature_reg[uart_pins_pkg::XFR_RS485_POL] ? sts.tx_busy : ~sts.tx_busy;
        end else if (auto_rts) begin
            st_nxt.rts_n = sts.rx_above_trigger;
        end else begin
            st_nxt.rts_n = ~rts_manual;
        end

        st_nxt.tx_hold = ctl.enhanced_feature_reg[uart_pins_pkg::EFR_AUTO_CTS] && st_r.cts_s[1];

        // Flow events for the core's interrupt logic.
        st_nxt.flow_event =
            (ctl.enhanced_feature_reg[uart_pins_pkg::EFR_AUTO_CTS] && ctl.int_enable_reg[uart_pins_pkg::IER_CTS_INT] &&
             (st_r.cts_s[1] != st_r.cts_d)) ||
            (auto_rts && !rs485 && ctl.int_enable_reg[uart_pins_pkg::IER_RTS_INT] &&
             (st_nxt.rts_n != st_r.rts_n));

        st_nxt.dtr_n = ~ctl.modem_control_reg[uart_pins_pkg::MCR_DTR];
    end

    // State register; all pins rest inactive after reset.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_r <= '{mode_s: 2'h3, addr_s: '0, aen_s: 2'h3, sel_s: '0,
                      cts_s: 2'h3, rclk_s: 2'h0, aen_d: 1'b1, cts_d: 1'b1,
                      port_sel: 3'h0, pc_mode: 1'b0, com_select: 1'b0,
                      printer_port1_decode_n_n: 1'b1, printer_port2_decode_n_n: 1'b1, baud_out_n: 1'b1, rx_clk: 1'b0,
                      irq_o: 3'h0, irq_oe: 3'h0, rx_ready_n: 1'b1, rts_n: 1'b1,
                      dtr_n: 1'b1, tx_hold: 1'b0, flow_event: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Serial line coding and infrared decode.
    // infrared decoder on receive
    serial_line u_line (
        .core_clk(core_clk),
        .rstn(rstn),
        .ir_mode(ir_mode),
        .baud_tick(sts.baud_tick),
        .tx_serial(tx_serial),
        .tx_phase(tx_phase),
        .rx_serial(rx_serial),
        .rx_pin(rx_pin),
        .tx_pin(tx_pin)
    );

    // Outputs straight from the state register.
    assign rx_clk_16x = st_r.rx_clk;
    assign tx_hold = st_r.tx_hold;
    assign flow_event = st_r.flow_event;
    assign com_select = st_r.com_select;
    assign pc_mode = st_r.pc_mode;
    assign rx_ready_n = st_r.rx_ready_n;
    assign irq_line_o = st_r.irq_o;
    assign irq_line_oe = st_r.irq_oe;
    assign baud_clock_out_n = st_r.baud_out_n;
    assign printer_port2_decode_n = st_r.printer_port2_decode_n_n;
    assign rts_n = st_r.rts_n;
    assign dtr_n = st_r.dtr_n;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_RX_READY_N: assert property (sts.rx_data_ready |=> !rx_ready_n)
        else $error("Receiver ready not asserted.");
    AST_PC_STRAP: assert property ($fell(host.pc_mode_select_n) |-> ##3 pc_mode)
        else $error("PC mode not entered three cycles after strap low.");
    AST_COM_AEN: assert property (com_select |-> $past(!st_r.aen_s[1]))
        else $error("COM select without address valid.");
    AST_IRQ_ONEHOT: assert property (
        $onehot0(irq_line_oe) && ((irq_line_o & ~irq_line_oe) == 3'h0))
        else $error("Request lines not one-hot or drive while floating.");
    AST_IRQ_GATE: assert property (
        irq_line_oe != 3'h0 |-> $past(ctl.modem_control_reg[3]) && $past(pc_mode))
        else $error("Request line enabled without modem control bit.");
    AST_IRQ_ROUTE: assert property (
        pc_mode && irq_enable && sts.uart_irq |=> irq_line_o != 3'h0)
        else $error("Interrupt not routed.");
    AST_RX_CLK: assert property (pc_mode && sts.baud_tick |=> rx_clk_16x)
        else $error("Receiver clock not internal in PC mode.");
    AST_NON_PC: assert property (!pc_mode |=> irq_line_oe == 3'h0 && !com_select)
        else $error("PC decode active outside PC mode.");
    AST_CTS_STOP: assert property (ctl.enhanced_feature_reg[7] && st_r.cts_s[1] |=> tx_hold)
        else $error("Transmit not held while CTS deasserted.");
    AST_RS485: assert property (rs485 && !ctl.extra_feature_reg[5] && sts.tx_busy |=> !rts_n)
        else $error("RS485 direction not driven during transmit.");
    AST_DTR: assert property (ctl.modem_control_reg[0] |=> !dtr_n)
        else $error("DTR not asserted.");

    COV_IRQ: cover property (irq_line_o != 3'h0);
    COV_COM: cover property (com_select);
    COV_PRINTER_PORT1_DECODE_N: cover property (pc_mode && !baud_clock_out_n);
    COV_HOLD: cover property (tx_hold ##1 !tx_hold);

endmodule : uart_pin_ctrl

/* src/uart_pins_pkg.sv */
package uart_pins_pkg;

    // Bit positions inside the core's control registers.
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_IRQ_EN = 3;
    localparam int IER_SRC_LSB = 0;
    localparam int IER_SRC_MSB = 3;
    localparam int IER_RTS_INT = 6;
    localparam int IER_CTS_INT = 7;
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_AUTO_CTS = 7;
    localparam int XFR_RS485_EN = 2;
    localparam int XFR_RS485_POL = 5;

    // Host address bits 9..3 of the standard PC ports.
    localparam logic [6:0] COM1_BASE = 7'h7F;
    localparam logic [6:0] COM2_BASE = 7'h5F;
    localparam logic [6:0] COM3_BASE = 7'h7D;
    localparam logic [6:0] COM4_BASE = 7'h5D;
    localparam logic [6:0] PRINTER_PORT1_DECODE_N_BASE = 7'h6F;
    localparam logic [6:0] PRINTER_PORT2_DECODE_N_BASE = 7'h4F;

    // Interrupt request lines, one-hot.
    localparam logic [2:0] IRQ_A = 3'h1;
    localparam logic [2:0] IRQ_B = 3'h2;
    localparam logic [2:0] IRQ_C = 3'h4;

    // Infrared encoder pulse length in 16x ticks, and a full bit time.
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [3:0] BIT_TICKS_M1 = 4'hF;

    // Control registers of the core that steer the pin logic.
    typedef struct packed {
        logic [7:0] modem_control_reg;
        logic [7:0] int_enable_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] extra_feature_reg;
    } core_ctl_t;

    // Status from the core that reaches the pins.
    typedef struct packed {
        logic uart_irq;
        logic rx_data_ready;
        logic rx_above_trigger;
        logic tx_busy;
        logic baud_tick;
    } core_sts_t;

    // Strap and host decode pins.
    typedef struct packed {
        logic pc_mode_select_n;
        logic [6:0] host_addr;
        logic isa_address_valid_n;
        logic [2:0] port_select;
    } host_pins_t;

endpackage : uart_pins_pkg

/* test/isa_host_model.sv */
`timescale 1ns/10ps

// Host side of the bus: mode strap, COM straps, address lines and strobe.
module isa_host_model (
    // Clock.
    input wire logic core_clk,
    // Requests from the bench.
    input wire logic mode_n,
    input wire logic go,
    input wire logic [6:0] go_addr,
    input wire logic [2:0] go_sel,
    // Pins toward the device.
    output uart_pins_pkg::host_pins_t host
);
    initial host = {1'h1, 7'h00, 1'h1, 3'h0};

    // The address is only meaningful while the strobe is low, so it wanders otherwise.
    // strobe qualifies address
    always @(posedge core_clk) begin
        host.pc_mode_select_n <= mode_n;
        host.port_select <= go_sel;
        host.isa_address_valid_n <= ~go;
        host.host_addr <= go ? go_addr : ~host.host_addr;
    end
endmodule : isa_host_model

/* test/uart_pin_ctrl_tb_top.sv */
`timescale 1ns/10ps

module uart_pin_ctrl_tb_top;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    uart_pins_pkg::core_ctl_t ctl = '0;
    uart_pins_pkg::core_sts_t sts = '0;
    logic ir_mode = 1'h0;
    logic tx_serial = 1'h1;
    logic [3:0] tx_phase = 4'h0;
    logic rclk_pin = 1'h0;
    logic drive_disable_n = 1'h1;
    logic rx_pin = 1'h1;
    logic cts_n = 1'h0;
    logic mode_n = 1'h1;
    logic go = 1'h0;
    logic [6:0] go_addr = 7'h00;
    logic [2:0] go_sel = 3'h0;
    uart_pins_pkg::host_pins_t host;
    logic rx_serial, rx_clk_16x, tx_hold, flow_event, com_select, pc_mode;
    logic rx_ready_n, baud_clock_out_n, printer_port2_decode_n, tx_pin, rts_n, dtr_n;
    logic [2:0] irq_line_o, irq_line_oe;
    logic seen;
    int failures = 0;
    int check_count = 0;
    logic [6:0] com_base [4] = '{uart_pins_pkg::COM1_BASE, uart_pins_pkg::COM2_BASE,
        uart_pins_pkg::COM3_BASE, uart_pins_pkg::COM4_BASE};

    // A 40 ns clock.
    always #20 core_clk = ~core_clk;

    isa_host_model u_host (.core_clk(core_clk), .mode_n(mode_n), .go(go),
        .go_addr(go_addr), .go_sel(go_sel), .host(host));

    uart_pin_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .ctl(ctl), .sts(sts),
        .ir_mode(ir_mode), .tx_serial(tx_serial), .tx_phase(tx_phase),
        .rx_serial(rx_serial), .rx_clk_16x(rx_clk_16x), .tx_hold(tx_hold),
        .flow_event(flow_event), .com_select(com_select), .pc_mode(pc_mode),
        .host(host), .rclk_pin(rclk_pin), .drive_disable_n(drive_disable_n),
        .rx_ready_n(rx_ready_n), .irq_line_o(irq_line_o), .irq_line_oe(irq_line_oe),
        .baud_clock_out_n(baud_clock_out_n),
        .printer_port2_decode_n(printer_port2_decode_n), .rx_pin(rx_pin),
        .cts_n(cts_n), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n));

    // Waits for edges, then steps 1 ns past the last one to drive or sample.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk3

    task automatic chk1(input logic got, input logic exp);
        chk3({2'h0, got}, {2'h0, exp});
    endtask : chk1

    // One host cycle: strobe high with new straps, then address and strobe low, held.
    task automatic host_cycle(input logic [6:0] addr, input logic [2:0] sel);
        go = 1'h0;
        go_sel = sel;
        tick(4);
        go_addr = addr;
        go = 1'h1;
        tick(7);
    endtask : host_cycle

    task automatic pulse_baud(input int n);
        repeat (n) begin
            sts.baud_tick = 1'h1;
            tick(1);
            sts.baud_tick = 1'h0;
            tick(1);
        end
    endtask : pulse_baud

    function automatic logic [2:0] exp_line(input logic [2:0] sel);
        if (sel[2]) return uart_pins_pkg::IRQ_C;
        return sel[0] ? uart_pins_pkg::IRQ_B : uart_pins_pkg::IRQ_A;
    endfunction : exp_line

    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // Cuts a hang short; the tests need well under 2000 cycles.
    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        tick(12);
        chk3(irq_line_oe, 3'h0);
        chk1(dtr_n, 1'h1);
        rstn = 1'h1;
        ctl.modem_control_reg = 8'h08;
        ctl.int_enable_reg = 8'h01;
        sts.uart_irq = 1'h1;
        host_cycle(uart_pins_pkg::COM1_BASE, 3'h0);
        chk1(com_select, 1'h0);
        chk3(irq_line_oe, 3'h0);
        drive_disable_n = 1'h0;
        sts.baud_tick = 1'h1;
        rclk_pin = 1'h1;
        tick(1);
        chk1(baud_clock_out_n, 1'h0);
        sts.baud_tick = 1'h0;
        tick(4);
        chk1(printer_port2_decode_n, 1'h0);
        chk1(rx_clk_16x, 1'h1);
        drive_disable_n = 1'h1;
        mode_n = 1'h0;
        tick(6);
        chk1(pc_mode, 1'h1);
        chk1(rx_clk_16x, 1'h0);
        rclk_pin = 1'h0;
        for (int s = 0; s < 8; s++) begin
            host_cycle(com_base[s[1:0]], s[2:0]);
            chk1(com_select, 1'h1);
            chk3(irq_line_oe, exp_line(s[2:0]));
            chk3(irq_line_o, exp_line(s[2:0]));
            host_cycle(com_base[s[1:0] ^ 2'h1], s[2:0]);
            chk1(com_select, 1'h0);
        end
        ctl.modem_control_reg[uart_pins_pkg::MCR_IRQ_EN] = 1'h0;
        tick(2);
        chk3(irq_line_oe, 3'h0);
        ctl.modem_control_reg[uart_pins_pkg::MCR_IRQ_EN] = 1'h1;
        ctl.int_enable_reg = 8'h00;
        tick(2);
        chk3(irq_line_oe, 3'h0);
        ctl.int_enable_reg = 8'h01;
        tick(2);
        chk3(irq_line_oe, uart_pins_pkg::IRQ_C);
        host_cycle(uart_pins_pkg::PRINTER_PORT1_DECODE_N_BASE, 3'h0);
        chk1(baud_clock_out_n, 1'h0);
        chk1(printer_port2_decode_n, 1'h1);
        host_cycle(uart_pins_pkg::PRINTER_PORT2_DECODE_N_BASE, 3'h0);
        chk1(printer_port2_decode_n, 1'h0);
        chk1(baud_clock_out_n, 1'h1);
        for (int b = 0; b < 7; b++) begin
            host_cycle(uart_pins_pkg::PRINTER_PORT2_DECODE_N_BASE ^ (7'h01 << b), 3'h0);
            chk1(printer_port2_decode_n, 1'h1);
        end
        sts.baud_tick = 1'h1;
        tick(1);
        chk1(rx_clk_16x, 1'h1);
        sts.baud_tick = 1'h0;
        tick(1);
        chk1(rx_clk_16x, 1'h0);
        sts.rx_data_ready = 1'h1;
        ctl.modem_control_reg[uart_pins_pkg::MCR_DTR] = 1'h1;
        tx_serial = 1'h0;
        tick(2);
        chk1(rx_ready_n, 1'h0);
        chk1(dtr_n, 1'h0);
        chk1(tx_pin, 1'h0);
        sts.rx_data_ready = 1'h0;
        tx_serial = 1'h1;
        rx_pin = 1'h0;
        tick(5);
        chk1(rx_ready_n, 1'h1);
        chk1(tx_pin, 1'h1);
        chk1(rx_serial, 1'h0);
        // Infrared idle is low on both lines.
        ir_mode = 1'h1;
        tx_serial = 1'h0;
        for (int ph = 0; ph < 16; ph++) begin
            tx_phase = 4'(ph);
            tick(2);
            chk1(tx_pin, ph < uart_pins_pkg::IR_PULSE_TICKS);
        end
        tx_serial = 1'h1;
        tick(4);
        chk1(rx_serial, 1'h1);
        rx_pin = 1'h1;
        tick(2);
        rx_pin = 1'h0;
        tick(5);
        chk1(rx_serial, 1'h0);
        pulse_baud(14);
        chk1(rx_serial, 1'h0);
        pulse_baud(4);
        chk1(rx_serial, 1'h1);
        // Wired idle again; software raises the request line before automatic use.
        ir_mode = 1'h0;
        rx_pin = 1'h1;
        ctl.modem_control_reg[uart_pins_pkg::MCR_RTS] = 1'h1;
        ctl.enhanced_feature_reg[uart_pins_pkg::EFR_AUTO_RTS] = 1'h1;
        ctl.int_enable_reg[uart_pins_pkg::IER_RTS_INT] = 1'h1;
        sts.rx_above_trigger = 1'h1;
        tick(2);
        chk1(rts_n, 1'h1);
        sts.rx_above_trigger = 1'h0;
        tick(2);
        chk1(rts_n, 1'h0);
        ctl.extra_feature_reg[uart_pins_pkg::XFR_RS485_EN] = 1'h1;
        sts.tx_busy = 1'h1;
        tick(2);
        chk1(rts_n, 1'h0);
        ctl.extra_feature_reg[uart_pins_pkg::XFR_RS485_POL] = 1'h1;
        tick(2);
        chk1(rts_n, 1'h1);
        ctl.enhanced_feature_reg[uart_pins_pkg::EFR_AUTO_CTS] = 1'h1;
        ctl.int_enable_reg[uart_pins_pkg::IER_CTS_INT] = 1'h1;
        cts_n = 1'h1;
        seen = 1'h0;
        repeat (6) begin
            tick(1);
            seen = seen | flow_event;
        end
        chk1(seen, 1'h1);
        chk1(tx_hold, 1'h1);
        cts_n = 1'h0;
        tick(5);
        chk1(tx_hold, 1'h0);
        ctl.enhanced_feature_reg[uart_pins_pkg::EFR_AUTO_CTS] = 1'h0;
        cts_n = 1'h1;
        mode_n = 1'h1;
        tick(6);
        chk1(tx_hold, 1'h0);
        chk1(pc_mode, 1'h0);
        chk3(irq_line_oe, 3'h0);
        wrap_up();
    end
endmodule : uart_pin_ctrl_tb_top
